// ==== verilog/clock_switch_defs.svh ====
/*
  constants of the glitchless clock switch: counts and widths.
  assumes it is included by bare name from the package and the modules.
*/
`ifndef CLOCK_SWITCH_DEFS_SVH
`define CLOCK_SWITCH_DEFS_SVH

`define CS_NUM_OUT      10
`define CS_SYNC_W       16
`define CS_DRAIN_MAX    2'h3
`define CS_HOLD_MAX     2'h3
`define CS_SEL_A        1'h0
`define CS_PD_LAT_US    100
`define CS_CLK_MHZ      25
`define CS_PD_LAT_CYC   (`CS_PD_LAT_US * `CS_CLK_MHZ)

`endif

// ==== verilog/clock_switch_pkg.sv ====
/*
  types of the glitchless clock switch.
  assumes clock_switch_defs.svh is on the include path.
*/
`default_nettype none
`include "clock_switch_defs.svh"

package clock_switch_pkg;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_DRAIN = 2'h1,
    ST_HOLD  = 2'h3
  } sw_state_t;

  typedef struct packed {
    logic input_select;
    logic force_select;
    logic disable_level_select;
    logic power_down_n;
  } ctrl_pins_t;

  typedef struct packed {
    logic [`CS_NUM_OUT-1:0] clock_output;
    logic [`CS_NUM_OUT-1:0] clock_output_n;
  } out_pair_t;

endpackage

`default_nettype wire

// ==== verilog/pin_sync.sv ====
/*
  two flip-flop synchroniser for a vector of asynchronous pins.
  assumes one clock and a synchronous active-high reset.
*/
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = reset ? '0 : async_in;
    nxt_sync = reset ? '0 : meta_ff;
  end

  always_ff @(posedge ref_clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ==== verilog/glitchless_clock_switch.sv ====
/*
  glitchless two-input clock switch with forced selection, output
  gating to an idle level, power-down and ten replicated outputs.
  assumes both source clocks and all control pins are asynchronous to
  ref_clk and slower than a quarter of it; they are sampled by ref_clk.
*/
`default_nettype none
`include "clock_switch_defs.svh"

module glitchless_clock_switch
  import clock_switch_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_a_in,
  input  wire logic                   clk_b_in,
  input  wire ctrl_pins_t             ctrl_pins,
  input  wire logic [`CS_NUM_OUT-1:0] output_gate_n,
  output var  out_pair_t              out_pair
);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  logic [`CS_SYNC_W-1:0] sync_vec;
  logic                  clk_a_s;
  logic                  clk_b_s;
  ctrl_pins_t            ctrl_s;
  logic [`CS_NUM_OUT-1:0] gate_n_s;

  // all pins pass two flops before use
  pin_sync #(.W(`CS_SYNC_W)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({clk_a_in, clk_b_in, ctrl_pins, output_gate_n}),
    .sync_out (sync_vec)
  );

  assign clk_a_s  = sync_vec[15];
  assign clk_b_s  = sync_vec[14];
  assign ctrl_s   = sync_vec[13:10];
  assign gate_n_s = sync_vec[9:0];

  sw_state_t state_ff;
  sw_state_t nxt_state;
  logic      cur_sel_ff;
  logic      nxt_cur_sel;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic      core_ff;
  logic      nxt_core;
  logic      force_d_ff;
  logic      nxt_force_d;
  logic      a_d_ff;
  logic      b_d_ff;
  logic      nxt_a_d;
  logic      nxt_b_d;

  logic old_clk;
  logic new_clk;
  logic old_prev;
  logic new_prev;
  logic force_rise;

  always_comb begin
    old_clk    = (cur_sel_ff == `CS_SEL_A) ? clk_a_s : clk_b_s;
    old_prev   = (cur_sel_ff == `CS_SEL_A) ? a_d_ff : b_d_ff;
    new_clk    = (ctrl_s.input_select == `CS_SEL_A) ? clk_a_s : clk_b_s;
    new_prev   = (ctrl_s.input_select == `CS_SEL_A) ? a_d_ff : b_d_ff;
    force_rise = ctrl_s.force_select & ~force_d_ff;
  end

  always_comb begin
    nxt_state   = state_ff;
    nxt_cur_sel = cur_sel_ff;
    nxt_cnt     = cnt_ff;
    nxt_core    = core_ff;
    nxt_force_d = ctrl_s.force_select;
    nxt_a_d     = clk_a_s;
    nxt_b_d     = clk_b_s;
    // a force edge wins over every state
    if (force_rise) begin
      // immediate low, restart from the selected input
      nxt_state   = ST_HOLD;
      nxt_core    = 1'h0;
      nxt_cnt     = 2'h0;
      nxt_cur_sel = ctrl_s.input_select;
    end else begin
      case (state_ff)
        ST_RUN: begin
          // run: core follows the chosen clock one edge late
          nxt_core = old_clk;
          if (ctrl_s.input_select != cur_sel_ff) begin
            if (ctrl_s.force_select) begin
              // old clock is never looked at again while forced
              nxt_state   = ST_HOLD;
              nxt_core    = 1'h0;
              nxt_cnt     = 2'h0;
              nxt_cur_sel = ctrl_s.input_select;
            end else begin
              nxt_state = ST_DRAIN;
              nxt_cnt   = 2'h0;
            end
          end
        end
        ST_DRAIN: begin
          // park low at a falling edge of the output
          nxt_core = old_clk & core_ff;
          if (rise(old_clk, old_prev)) begin
            nxt_cnt = cnt_ff + 2'h1;
          end
          if (!old_clk || cnt_ff == `CS_DRAIN_MAX) begin
            nxt_core    = 1'h0;
            nxt_state   = ST_HOLD;
            nxt_cnt     = 2'h0;
            nxt_cur_sel = ctrl_s.input_select;
          end
        end
        ST_HOLD: begin
          nxt_core = 1'h0;
          if (ctrl_s.input_select != cur_sel_ff) begin
            nxt_cur_sel = ctrl_s.input_select;
            nxt_cnt     = 2'h0;
          end else if (rise(new_clk, new_prev)) begin
            // low for at most three new cycles
            if (cnt_ff == `CS_HOLD_MAX - 2'h1) begin
              // restart on a rising edge, no short pulse
              nxt_core  = 1'h1;
              nxt_state = ST_RUN;
              nxt_cnt   = 2'h0;
            end else begin
              nxt_cnt = cnt_ff + 2'h1;
            end
          end
        end
        default: begin
          nxt_state = ST_HOLD;
          nxt_core  = 1'h0;
          nxt_cnt   = 2'h0;
        end
      endcase
    end
    // reset last: hold on input a with the core low
    if (reset) begin
      nxt_state   = ST_HOLD;
      nxt_cur_sel = `CS_SEL_A;
      nxt_cnt     = 2'h0;
      nxt_core    = 1'h0;
      nxt_force_d = 1'h0;
      nxt_a_d     = 1'h0;
      nxt_b_d     = 1'h0;
    end
  end

  // switch state registers only
  always_ff @(posedge ref_clk) begin
    state_ff   <= nxt_state;
    cur_sel_ff <= nxt_cur_sel;
    cnt_ff     <= nxt_cnt;
    core_ff    <= nxt_core;
    force_d_ff <= nxt_force_d;
    a_d_ff     <= nxt_a_d;
    b_d_ff     <= nxt_b_d;
  end

  logic [`CS_NUM_OUT-1:0] q_ff;
  logic [`CS_NUM_OUT-1:0] qn_ff;
  logic [`CS_NUM_OUT-1:0] nxt_q;
  logic [`CS_NUM_OUT-1:0] nxt_qn;

  genvar gi;
  generate
    for (gi = 0; gi < `CS_NUM_OUT; gi++) begin : g_out
      always_comb begin
        if (reset || !ctrl_s.power_down_n) begin
          // power-down: both lines high, zero swing
          nxt_q[gi]  = 1'h1;
          nxt_qn[gi] = 1'h1;
        end else if (gate_n_s[gi]) begin
          // same core clock on every output
          nxt_q[gi]  = core_ff;
          nxt_qn[gi] = ~core_ff;
        end else begin
          // disabled: static idle level
          nxt_q[gi]  = ctrl_s.disable_level_select;
          nxt_qn[gi] = ~ctrl_s.disable_level_select;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    q_ff  <= nxt_q;
    qn_ff <= nxt_qn;
  end

  assign out_pair.clock_output   = q_ff;
  assign out_pair.clock_output_n = qn_ff;

endmodule

`default_nettype wire

// ==== bench/clock_switch_sva.sv ====
/* checker: port assertions of the clock switch.
   assumes A and B run at 8 and 12 ref_clk cycles. */
`default_nettype none
`include "clock_switch_defs.svh"
module clock_switch_sva
  import clock_switch_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   reset,
  input wire ctrl_pins_t             ctrl_pins,
  input wire logic [`CS_NUM_OUT-1:0] output_gate_n,
  input wire out_pair_t              out_pair
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] up_ff;
  logic       up;
  assign up = up_ff == 3'h7;
  always_ff @(posedge ref_clk) begin
    up_ff <= (reset || !ctrl_pins.power_down_n) ? 3'h0 : up_ff + {2'h0, !up};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence turn;
    $changed(ctrl_pins.input_select) && !ctrl_pins.force_select && up
      && output_gate_n[0];
  endsequence
  a_pd_level:
    assert property ((!ctrl_pins.power_down_n) [*5] |-> &out_pair)
      else $error("power-down level wrong");
  a_pair_inverse:
    assert property (up |-> out_pair.clock_output_n == ~out_pair.clock_output)
      else $error("complement not inverse");
  a_all_equal:
    assert property ((up && &output_gate_n) [*5] |->
      (out_pair.clock_output == '0 || &out_pair.clock_output))
      else $error("outputs differ");
  a_gate_level:
    assert property ((up && !output_gate_n[0]
      && $stable(ctrl_pins.disable_level_select)) [*5] |->
      out_pair.clock_output[0] == ctrl_pins.disable_level_select)
      else $error("gated level wrong");
  a_force_low:
    assert property ($rose(ctrl_pins.force_select) && up && output_gate_n[0]
      |-> ##[1:4] !out_pair.clock_output[0]) else $error("force not low");
  a_select_park:
    assert property (turn |-> ##[1:40] !out_pair.clock_output[0])
      else $error("switch not parked");
  a_restart_bound:
    assert property (turn |-> ##[1:90] $rose(out_pair.clock_output[0]))
      else $error("no restart");
  a_no_runt:
    assert property ($rose(out_pair.clock_output[0]) && output_gate_n[0]
      && !ctrl_pins.force_select |=> out_pair.clock_output[0] [*2])
      else $error("short pulse");
  cover property ($rose(ctrl_pins.force_select));
  cover property (turn);
  cover property (up && !output_gate_n[0]);
endmodule
bind glitchless_clock_switch clock_switch_sva chk (
  .ref_clk, .reset, .ctrl_pins, .output_gate_n, .out_pair);
`default_nettype wire

// ==== bench/clock_source_model.sv ====
/* partner: source clocks A and B made from ref_clk.
   assumes the bench drives dead; a dead source parks low. */
`default_nettype none
module clock_source_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] dead,
  output var  logic       clk_a_in,
  output var  logic       clk_b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int ca = 0;
  int cb = 0;
  initial begin
    clk_a_in = 1'b0;
    clk_b_in = 1'b0;
  end
  // a dying source ends its half cycle, then stays low
  // dead is read on the edge, clocks move by non-blocking update
  always @(posedge ref_clk) begin
    ca = (ca + 1) % 4;
    cb = (cb + 1) % 6;
    // an unused source keeps running unless killed
    if (ca == 0) clk_a_in <= !dead[0] && !clk_a_in;
    if (cb == 0) clk_b_in <= !dead[1] && !clk_b_in;
  end
endmodule
`default_nettype wire

// ==== bench/test_glitchless_clock_switch.sv ====
/* bench: drives the clock switch and compares with a model.
   assumes clock_source_model makes A (8) and B (12 cycles). */
`default_nettype none
`include "clock_switch_defs.svh"
module test_glitchless_clock_switch
  import clock_switch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk;
  logic                   reset;
  logic [1:0]             dead;
  logic                   clk_a_in;
  logic                   clk_b_in;
  ctrl_pins_t             ctl;
  logic [`CS_NUM_OUT-1:0] gate_n;
  out_pair_t              out_pair;
  logic [31:0]            r;
  int                     n_fail = 0;
  int                     samples_checked = 0;
  clock_source_model src (.ref_clk, .dead, .clk_a_in, .clk_b_in);
  glitchless_clock_switch dut (.ref_clk, .reset, .clk_a_in, .clk_b_in,
    .ctrl_pins(ctl), .output_gate_n(gate_n), .out_pair);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end
  // expected outputs while the core is parked low
  function automatic out_pair_t model(logic [9:0] en, logic lv, logic pd);
    out_pair_t m;
    m.clock_output = pd ? ~en & {10{lv}} : '1;
    m.clock_output_n = pd ? ~m.clock_output : '1;
    return m;
  endfunction
  task results();
    $display("compared %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk_pair(string nm, out_pair_t e);
    samples_checked++;
    if (out_pair !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, out_pair);
    end
  endtask
  // cycles between two rises of the first output
  task chk_gap(string nm, int e);
    int t0;
    int g;
    logic p;
    t0 = -1;
    g = -1;
    p = 1'b1;
    for (int i = 0; i < 200 && g < 0; i++) begin
      step(1);
      if (p === 1'b0 && out_pair.clock_output[0] === 1'b1)
        if (t0 < 0) t0 = i;
        else g = i - t0;
      p = out_pair.clock_output[0];
    end
    samples_checked++;
    if (g != e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task swap(logic s, int e);
    ctl.force_select = 1'b0;
    step(1);
    ctl.input_select = s;
    step(1);
    ctl.force_select = 1'b1;
    chk_gap("swap gap", e);
  endtask
  initial begin
    void'($urandom(32'h4AE27BC3));
    reset = 1'b1;
    dead = 2'h0;
    gate_n = '1;
    ctl = 4'h1;
    step(3);
    chk_pair("reset", model('1, 1'b0, 1'b0));
    reset = 1'b0;
    chk_gap("gap A", 8);
    ctl.input_select = 1'b1;
    chk_gap("gap B", 12);
    dead = 2'h2;
    ctl.input_select = 1'b0;
    ctl.force_select = 1'b1;
    chk_gap("forced gap", 8);
    dead = 2'h0;
    swap(1'b1, 12);
    swap(1'b0, 8);
    dead = 2'h2;
    chk_gap("deselected dead", 8);
    dead = 2'h1;
    step(12);
    repeat (3) begin
      r = $urandom;
      gate_n = r[9:0];
      ctl.disable_level_select = r[10];
      step(6);
      chk_pair("gated", model(gate_n, r[10], 1'b1));
    end
    gate_n = '0;
    ctl.disable_level_select = 1'b1;
    step(6);
    ctl.power_down_n = 1'b0;
    step(4);
    chk_pair("down", model('0, 1'b1, 1'b0));
    ctl.power_down_n = 1'b1;
    step(8);
    chk_pair("woken", model('0, 1'b1, 1'b1));
    results();
  end
  initial begin
    #160000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
